/* File: core/fplc_consts.vh */
`ifndef FPLC_CONSTS_VH
`define FPLC_CONSTS_VH
// ****************************************************************
// Register offsets (byte addresses, one word each)
// ****************************************************************
`define FPLC_REG_CTRL 8'h00
`define FPLC_REG_STATUS 8'h04
`define FPLC_REG_SETUP 8'h08
`define FPLC_REG_SEL 8'h0C
`define FPLC_REG_LVL_WIN 8'h10
`define FPLC_REG_LVL_DATA 8'h14
`define FPLC_REG_METER 8'h18
// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define FPLC_CTRL_RESTORE 0
`define FPLC_CTRL_LINK 1
`define FPLC_STAT_MODE 0
`define FPLC_STAT_LINK 1
`define FPLC_STAT_BUSY 2
`define FPLC_SETUP_RST 16'h0000
// Targets: 4 inputs, 6 lines, phones, coax out, 8 optical outs
`define FPLC_NUM_TGT 5'd20
`define FPLC_TGT_LINE0 5'd4
`define FPLC_TGT_HP 5'd10
`define FPLC_TGT_COAX 5'd11
`define FPLC_TGT_OPT0 5'd12
// Level codes: mic 0=0dB,10..65; inst half-dB 0..36; out 0=mute,1..65 (-58..+6)
`define FPLC_MIC_MIN 7'd10
`define FPLC_MIC_MAX 7'd65
`define FPLC_INST_MAX 7'd36
`define FPLC_OUT_MAX 7'd65
`define FPLC_OUT_UNITY 7'd59
// Meter thresholds on 16-bit peak magnitude
// Signal lights above SIG_THR (from -65 dBFS), overload at OVL_THR (-2 dBFS) and up
`define FPLC_SIG_THR 16'h0012
`define FPLC_OVL_THR 16'h65AC
// Timing
`define FPLC_CLK_HZ 50000000
`define FPLC_LONG_MS 1000
`define FPLC_DEB_US 2000
`endif

/* File: core/fplc_debounce.v */
`timescale 1ns/1ps
// ****************************************************************
// Three-flop synchroniser with stable-count filter
// ****************************************************************
module fplc_debounce #(
   parameter CNT = 100000
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Raw pin and clean level
   input wire pin,
   output reg clean_ff
);
   reg s1_ff;
   reg s2_ff;
   reg s3_ff;
   reg [23:0] cnt_ff;
   // Change counts when stage two and three agree and differ from output
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
         cnt_ff <= 24'h000000;
         clean_ff <= 1'b0;
      end else begin
         s1_ff <= pin;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff != s3_ff || s3_ff == clean_ff) begin
            cnt_ff <= 24'h000000;
         end else if (cnt_ff >= CNT[23:0]) begin
            clean_ff <= s3_ff;
            cnt_ff <= 24'h000000;
         end else begin
            cnt_ff <= cnt_ff + 24'h000001;
         end
      end
   end
endmodule // fplc_debounce

/* File: core/fplc_mem.v */
`timescale 1ns/1ps
// ****************************************************************
// Level store, one entry per target, registered read
// ****************************************************************
module fplc_mem #(
   parameter AW = 5,
   parameter DW = 7,
   parameter DEPTH = 20
) (
   // Clock
   input wire clk,
   // Write port
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [DW-1:0] wdata,
   // Read port
   input wire [AW-1:0] raddr,
   output reg [DW-1:0] rdata_ff
);
   reg [DW-1:0] mem [0:DEPTH-1];
   // Memory holds no reset; the top reloads the saved image after reset
   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata_ff <= mem[raddr];
   end
endmodule // fplc_mem

/* File: core/fplc_top.v */
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "fplc_consts.vh"
// Notes on behaviour
// - Any setting change triggers a full save; saved image reloads after each reset.
// - Saved image holds rate, clock mode, channel/digital setup and all levels.
// - Encoder is in channel or level mode; short push toggles them.
// - Green indicator output shows the active encoder mode.
// - Channel mode steps 4 inputs, 6 lines, phones, coax, 8 optical with labels.
// - Mic gains 10 to 65 dB in 1 dB, plus a 0 dB setting.
// - Instrument gains 0 to 18 dB in half-dB steps.
// - Half-dB instrument values light the display dot.
// - Outputs +6 to -58 dB in 1 dB steps, plus mute below.
// - Output levels go to mixer scaling; input gains go to analog hardware.
// - Hold over one second toggles stereo link; display shows off or on.
// - Linked selection offers left channels only; level written to both.
// - Per input pair, signal LED above -65 dBFS, overload LED at -2 dBFS.
// - Host and encoder both write the same instrument gain store.
module fplc_top #(
   parameter DEB_CYC = (`FPLC_CLK_HZ / 1000000) * `FPLC_DEB_US,
   parameter LONG_CYC = (`FPLC_CLK_HZ / 1000) * `FPLC_LONG_MS,
   parameter NV_AW = 5
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // Front panel pins
   input wire enc_a,
   input wire enc_b,
   input wire enc_push,
   output reg [4:0] disp_target_ff,
   output reg [6:0] disp_value_ff,
   output reg disp_show_level_ff,
   output reg disp_show_link_ff,
   output reg disp_dot_ff,
   output reg led_mode_green_ff,
   output reg [1:0] led_signal_ff,
   output reg [1:0] led_over_ff,
   // Input pair peak levels
   input wire [15:0] peak_pair0,
   input wire [15:0] peak_pair1,
   // Analog gain and mixer scaling
   output reg [4:0] gain_addr_ff,
   output reg [6:0] gain_code_ff,
   output reg gain_we_ff,
   output reg [4:0] mix_addr_ff,
   output reg [6:0] mix_code_ff,
   output reg mix_we_ff,
   // Non-volatile store (word-wide)
   output reg [NV_AW-1:0] nv_addr_ff,
   output reg [15:0] nv_wdata_ff,
   output reg nv_we_ff,
   output reg nv_re_ff,
   input wire [15:0] nv_rdata,
   input wire nv_done
);
   // ****************************************************************
   // States
   // ****************************************************************
   localparam ST_INIT = 5'b00001;
   localparam ST_LOAD = 5'b00010;
   localparam ST_IDLE = 5'b00100;
   localparam ST_SAVE = 5'b01000;
   localparam ST_WAIT = 5'b10000;
   localparam NV_SETUP = 5'd20;
   localparam NV_LAST = 5'd20;

   wire a_c;
   wire b_c;
   wire p_c;
   wire [6:0] mem_rd;
   reg [4:0] st_ff;
   reg [4:0] idx_ff;
   reg [15:0] setup_ff;
   reg mode_ff;
   reg link_ff;
   reg [4:0] sel_ff;
   reg dirty_ff;
   reg a_d_ff;
   reg p_d_ff;
   reg [26:0] hold_ff;
   reg long_ff;
   reg [4:0] win_ff;
   reg m_we;
   reg [4:0] m_wa;
   reg [6:0] m_wd;
   reg [4:0] m_ra;
   reg [1:0] pend_ff;
   reg [6:0] edit_ff;
   reg wait_ff;
   reg cp_ff;

   // Clamp step in range for the target's class
   function [6:0] step_val;
      input [4:0] t;
      input [6:0] v;
      input up;
      begin
         step_val = v;
         if (t < 5'd2) begin
            if (up) begin
               if (v == 7'd0) begin
                  step_val = `FPLC_MIC_MIN;
               end else if (v < `FPLC_MIC_MAX) begin
                  step_val = v + 7'd1;
               end
            end else if (v == `FPLC_MIC_MIN) begin
               step_val = 7'd0;
            end else if (v > `FPLC_MIC_MIN) begin
               step_val = v - 7'd1;
            end
         end else if (t < `FPLC_TGT_LINE0) begin
            if (up && v < `FPLC_INST_MAX) begin
               step_val = v + 7'd1;
            end else if (!up && v != 7'd0) begin
               step_val = v - 7'd1;
            end
         end else begin
            if (up && v < `FPLC_OUT_MAX) begin
               step_val = v + 7'd1;
            end else if (!up && v != 7'd0) begin
               step_val = v - 7'd1;
            end
         end
      end
   endfunction

   // Partner of a left target in a pair; inputs pair 0/1 and 2/3
   function [4:0] partner;
      input [4:0] t;
      begin
         partner = t;
         if (t == `FPLC_TGT_HP || t == `FPLC_TGT_COAX) begin
            partner = t;
         end else if (t < `FPLC_TGT_HP) begin
            partner = t + 5'd1;
         end else begin
            partner = t + 5'd1;
         end
      end
   endfunction

   fplc_debounce #(.CNT(DEB_CYC)) u_deb_a (.clk(clk), .rst_n(rst_n), .pin(enc_a), .clean_ff(a_c));
   fplc_debounce #(.CNT(DEB_CYC)) u_deb_b (.clk(clk), .rst_n(rst_n), .pin(enc_b), .clean_ff(b_c));
   fplc_debounce #(.CNT(DEB_CYC)) u_deb_p (.clk(clk), .rst_n(rst_n), .pin(enc_push), .clean_ff(p_c));

   fplc_mem #(.AW(5), .DW(7), .DEPTH(20)) u_mem (
      .clk(clk),
      .we(m_we),
      .waddr(m_wa),
      .wdata(m_wd),
      .raddr(m_ra),
      .rdata_ff(mem_rd)
   );

   // ****************************************************************
   // Encoder events
   // ****************************************************************
   wire detent = a_c & ~a_d_ff;
   wire dir_up = ~b_c;
   wire push_rel = ~p_c & p_d_ff;
   wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
   wire host_lvl = wb_wr && wb_adr_i == `FPLC_REG_LVL_DATA && st_ff == ST_IDLE;
   wire host_set = wb_wr && (wb_adr_i == `FPLC_REG_SETUP || wb_adr_i == `FPLC_REG_CTRL);
   wire knob_lvl = detent && mode_ff && st_ff == ST_IDLE && pend_ff == 2'd0;
   wire [6:0] knob_v = step_val(sel_ff, edit_ff, dir_up);

   // Memory port steering: load, host write, knob write, pair copy
   always @* begin
      m_we = 1'b0;
      m_wa = sel_ff;
      m_wd = knob_v;
      m_ra = (pend_ff != 2'd0) ? sel_ff : win_ff; // Panel refresh, else host window
      if (st_ff == ST_SAVE || st_ff == ST_WAIT) begin
         m_ra = idx_ff;
      end
      if (st_ff == ST_LOAD && nv_done && idx_ff != NV_SETUP) begin
         m_we = 1'b1;
         m_wa = idx_ff;
         m_wd = nv_rdata[6:0];
      end else if (host_lvl) begin
         m_we = 1'b1;
         m_wa = win_ff;
         m_wd = wb_dat_i[6:0];
      end else if (knob_lvl) begin
         m_we = 1'b1;
      end else if (cp_ff) begin
         m_we = 1'b1;
         m_wa = partner(sel_ff);
         m_wd = edit_ff;
      end
   end

   // ****************************************************************
   // Main control
   // ****************************************************************
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= ST_INIT;
         idx_ff <= 5'd0;
         setup_ff <= `FPLC_SETUP_RST;
         mode_ff <= 1'b0;
         link_ff <= 1'b0;
         sel_ff <= 5'd0;
         dirty_ff <= 1'b0;
         a_d_ff <= 1'b0;
         p_d_ff <= 1'b0;
         hold_ff <= 27'd0;
         long_ff <= 1'b0;
         win_ff <= 5'd0;
         pend_ff <= 2'd0;
         edit_ff <= 7'd0;
         wait_ff <= 1'b0;
         cp_ff <= 1'b0;
         nv_addr_ff <= {NV_AW{1'b0}};
         nv_wdata_ff <= 16'h0000;
         nv_we_ff <= 1'b0;
         nv_re_ff <= 1'b0;
         gain_addr_ff <= 5'd0;
         gain_code_ff <= 7'd0;
         gain_we_ff <= 1'b0;
         mix_addr_ff <= 5'd0;
         mix_code_ff <= 7'd0;
         mix_we_ff <= 1'b0;
         disp_target_ff <= 5'd0;
         disp_value_ff <= 7'd0;
         disp_show_level_ff <= 1'b0;
         disp_show_link_ff <= 1'b0;
         disp_dot_ff <= 1'b0;
         led_mode_green_ff <= 1'b0;
         led_signal_ff <= 2'b00;
         led_over_ff <= 2'b00;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         a_d_ff <= a_c;
         p_d_ff <= p_c;
         nv_we_ff <= 1'b0;
         nv_re_ff <= 1'b0;
         gain_we_ff <= 1'b0;
         mix_we_ff <= 1'b0;
         wb_ack_o <= wb_req;
         if (pend_ff != 2'd0) begin
            pend_ff <= pend_ff - 2'd1;
         end
         // route level change to its hardware
         if (m_we && st_ff != ST_LOAD) begin
            dirty_ff <= 1'b1;
            if (m_wa < `FPLC_TGT_LINE0) begin
               gain_addr_ff <= m_wa;
               gain_code_ff <= m_wd;
               gain_we_ff <= 1'b1;
            end else begin
               mix_addr_ff <= m_wa;
               mix_code_ff <= m_wd;
               mix_we_ff <= 1'b1;
            end
         end
         // Push: long hold toggles link once, short release toggles mode
         if (p_c) begin
            if (hold_ff < LONG_CYC[26:0]) begin
               hold_ff <= hold_ff + 27'd1;
            end else if (!long_ff) begin
               long_ff <= 1'b1;
               link_ff <= ~link_ff;
               sel_ff <= sel_ff & 5'b11110;
               disp_show_link_ff <= 1'b1;
               dirty_ff <= 1'b1;
            end
         end else begin
            hold_ff <= 27'd0;
            long_ff <= 1'b0;
         end
         if (push_rel && !long_ff) begin
            mode_ff <= ~mode_ff;
            disp_show_link_ff <= 1'b0;
            pend_ff <= 2'd2;
         end
         if (detent && !mode_ff) begin
            disp_show_link_ff <= 1'b0;
            pend_ff <= 2'd2;
            if (dir_up && sel_ff + (link_ff ? 5'd2 : 5'd1) < `FPLC_NUM_TGT) begin
               sel_ff <= sel_ff + (link_ff ? 5'd2 : 5'd1);
            end else if (!dir_up && sel_ff >= (link_ff ? 5'd2 : 5'd1)) begin
               sel_ff <= sel_ff - (link_ff ? 5'd2 : 5'd1);
            end
         end
         if (pend_ff == 2'd1) begin
            edit_ff <= mem_rd;
         end
         if (knob_lvl) begin
            edit_ff <= knob_v;
            pend_ff <= 2'd2;
         end
         // linked level goes to the right channel next cycle
         cp_ff <= knob_lvl & link_ff;
         // host level write refreshes the panel copy
         if (host_lvl) begin
            pend_ff <= 2'd2;
         end
         // Host register writes
         if (wb_wr) begin
            case (wb_adr_i)
               `FPLC_REG_CTRL: begin
                  link_ff <= wb_dat_i[`FPLC_CTRL_LINK];
                  dirty_ff <= 1'b1;
                  if (wb_dat_i[`FPLC_CTRL_RESTORE] && st_ff == ST_IDLE) begin
                     st_ff <= ST_INIT;
                  end
               end
               `FPLC_REG_SETUP: begin
                  setup_ff <= wb_dat_i[15:0];
                  dirty_ff <= 1'b1;
               end
               `FPLC_REG_LVL_WIN: begin
                  win_ff <= wb_dat_i[4:0];
               end
               default: begin
               end
            endcase
         end
         // Host reads
         case (wb_adr_i)
            `FPLC_REG_CTRL: wb_dat_o <= {30'h00000000, link_ff, 1'b0};
            `FPLC_REG_STATUS: wb_dat_o <= {29'h00000000, st_ff != ST_IDLE, link_ff, mode_ff};
            `FPLC_REG_SETUP: wb_dat_o <= {16'h0000, setup_ff};
            `FPLC_REG_SEL: wb_dat_o <= {27'h0000000, sel_ff};
            `FPLC_REG_LVL_WIN: wb_dat_o <= {27'h0000000, win_ff};
            `FPLC_REG_LVL_DATA: wb_dat_o <= {25'h0000000, mem_rd};
            `FPLC_REG_METER: wb_dat_o <= {28'h0000000, led_over_ff, led_signal_ff};
            default: wb_dat_o <= 32'h00000000;
         endcase
         // Non-volatile sequencing
         case (st_ff)
            ST_INIT: begin
               idx_ff <= 5'd0;
               nv_addr_ff <= {NV_AW{1'b0}};
               nv_re_ff <= 1'b1;
               st_ff <= ST_LOAD;
            end
            ST_LOAD: begin
               if (nv_done) begin
                  if (idx_ff == NV_SETUP) begin
                     // setup word carries rate, clock mode, I/O setup
                     setup_ff <= nv_rdata;
                     link_ff <= nv_rdata[15];
                     dirty_ff <= 1'b0;
                     st_ff <= ST_IDLE;
                  end else begin
                     idx_ff <= idx_ff + 5'd1;
                     nv_addr_ff <= idx_ff[NV_AW-1:0] + 1'b1;
                     nv_re_ff <= 1'b1;
                  end
               end
            end
            ST_IDLE: begin
               if (dirty_ff && !m_we && !host_set) begin
                  dirty_ff <= 1'b0;
                  idx_ff <= 5'd0;
                  st_ff <= ST_SAVE;
               end
            end
            ST_SAVE: begin
               // Memory read of idx lands one cycle later
               wait_ff <= 1'b0;
               st_ff <= ST_WAIT;
            end
            ST_WAIT: begin
               // One write per word; a second strobe would restart the store
               if (!wait_ff) begin
                  wait_ff <= 1'b1;
                  nv_addr_ff <= idx_ff[NV_AW-1:0];
                  nv_wdata_ff <= (idx_ff == NV_SETUP) ? {link_ff, setup_ff[14:0]} : {9'h000, mem_rd};
                  nv_we_ff <= 1'b1;
               end else if (nv_done) begin
                  if (idx_ff == NV_LAST) begin
                     st_ff <= ST_IDLE;
                  end else begin
                     idx_ff <= idx_ff + 5'd1;
                     st_ff <= ST_SAVE;
                  end
               end
            end
            default: st_ff <= ST_INIT;
         endcase
         led_mode_green_ff <= mode_ff;
         disp_target_ff <= sel_ff;
         disp_show_level_ff <= mode_ff;
         disp_value_ff <= disp_show_link_ff ? {6'h00, link_ff} : edit_ff;
         disp_dot_ff <= sel_ff >= 5'd2 && sel_ff < `FPLC_TGT_LINE0 && edit_ff[0];
         // signal and overload LEDs per pair
         led_signal_ff <= {peak_pair1 > `FPLC_SIG_THR, peak_pair0 > `FPLC_SIG_THR};
         led_over_ff <= {peak_pair1 >= `FPLC_OVL_THR, peak_pair0 >= `FPLC_OVL_THR};
      end
   end
endmodule // fplc_top

/* File: tb/fplc_chk.sv */
`timescale 1ns/1ps
// ****************************************************************
// Port-level checks on the panel controller
// ****************************************************************
module fplc_chk (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Bus handshake
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o,
   // Panel outputs
   input wire [4:0] disp_target_ff,
   input wire disp_show_level_ff,
   input wire disp_show_link_ff,
   input wire disp_dot_ff,
   input wire led_mode_green_ff,
   input wire [1:0] led_signal_ff,
   input wire [1:0] led_over_ff,
   // Gain, mixer and store strobes
   input wire [4:0] gain_addr_ff,
   input wire [6:0] gain_code_ff,
   input wire gain_we_ff,
   input wire [4:0] mix_addr_ff,
   input wire [6:0] mix_code_ff,
   input wire mix_we_ff,
   input wire nv_we_ff,
   input wire nv_re_ff
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // Bus answer comes one cycle after a taken request and lasts one cycle
   a_ack_after_req:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack after request");
   a_ack_one_pulse:
      assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   a_mode_led_match:
      assert property (!disp_show_link_ff |-> led_mode_green_ff == disp_show_level_ff) else $error("mode led wrong");
   a_dot_inst_only:
      assert property (disp_dot_ff |-> disp_target_ff inside {5'h02, 5'h03}) else $error("dot off inst input");
   a_target_in_range:
      assert property (disp_target_ff < 5'h14) else $error("target out of range");
   a_gain_path_inputs:
      assert property (gain_we_ff |-> gain_addr_ff < 5'h04) else $error("gain write to output");
   a_mix_path_outputs:
      assert property (mix_we_ff |-> mix_addr_ff inside {[5'h04:5'h13]} && mix_code_ff <= 7'h41)
         else $error("mixer write bad");
   a_mic_code_legal:
      assert property (gain_we_ff && gain_addr_ff < 5'h02 |-> gain_code_ff == 7'h00 ||
         gain_code_ff inside {[7'h0A:7'h41]}) else $error("mic code bad");
   a_inst_code_legal:
      assert property (gain_we_ff && gain_addr_ff inside {5'h02, 5'h03} |-> gain_code_ff <= 7'h24)
         else $error("inst code bad");
   a_over_needs_sig:
      assert property ((led_over_ff & ~led_signal_ff) == 2'h0) else $error("overload without signal");
   a_store_one_op:
      assert property (!(nv_we_ff && nv_re_ff)) else $error("store read and write together");
   // Main scenarios seen
   c_gain: cover property (gain_we_ff);
   c_mix: cover property (mix_we_ff);
   c_save: cover property (nv_we_ff);
   c_link: cover property ($rose(disp_show_link_ff));
endmodule // fplc_chk

bind fplc_top fplc_chk fplc_chk_i (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .disp_target_ff(disp_target_ff), .disp_show_level_ff(disp_show_level_ff),
   .disp_show_link_ff(disp_show_link_ff), .disp_dot_ff(disp_dot_ff), .led_mode_green_ff(led_mode_green_ff),
   .led_signal_ff(led_signal_ff), .led_over_ff(led_over_ff), .gain_addr_ff(gain_addr_ff),
   .gain_code_ff(gain_code_ff), .gain_we_ff(gain_we_ff), .mix_addr_ff(mix_addr_ff),
   .mix_code_ff(mix_code_ff), .mix_we_ff(mix_we_ff), .nv_we_ff(nv_we_ff), .nv_re_ff(nv_re_ff));

/* File: tb/fplc_nv_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// Non-volatile store model, answers two cycles after a request
// ****************************************************************
module fplc_nv_model (
   // Clock
   input wire clk,
   // Request
   input wire [4:0] addr,
   input wire [15:0] wdata,
   input wire we,
   input wire re,
   // Answer
   output logic [15:0] rdata,
   output logic done
);
   logic [15:0] mem [0:31];
   logic [4:0] a_ff;
   logic [1:0] cnt_ff;
   logic rd_ff;
   // Image left by an earlier session; it survives every reset
   initial begin
      foreach (mem[i]) mem[i] = 16'h0000;
      mem[0] = 16'h0014;
      mem[20] = 16'h00A5;
      rdata = 16'h5A5A;
      done = 1'b0;
      cnt_ff = 2'h0;
   end
   always @(posedge clk) begin
      done <= 1'b0;
      rdata <= ~rdata; // Stale data keeps toggling so it never looks valid
      if (we || re) begin
         cnt_ff <= 2'h2;
         a_ff <= addr;
         rd_ff <= re;
         if (we) mem[addr] <= wdata;
      end else if (cnt_ff != 2'h0) begin
         cnt_ff <= cnt_ff - 2'h1;
         if (cnt_ff == 2'h1) begin
            done <= 1'b1;
            if (rd_ff) rdata <= mem[a_ff];
         end
      end
   end
endmodule // fplc_nv_model

/* File: tb/fplc_top_tb.sv */
`timescale 1ns/1ps
`include "fplc_consts.vh"
// ****************************************************************
// Bench: bus and panel sequences with expected values
// ****************************************************************
module fplc_top_tb;
   logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic enc_a = 1'b0, enc_b = 1'b0, enc_push = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat_w = 32'h0, q;
   logic [15:0] peak0 = 16'h0000, peak1 = 16'h0000, nv_rdata, nv_wdata;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, show_lvl, show_link, dot, green, gain_we, mix_we, nv_we, nv_re, nv_done;
   wire [4:0] tgt, gain_addr, mix_addr, nv_addr;
   wire [6:0] value, gain_code, mix_code;
   wire [1:0] led_sig, led_over;
   logic [11:0] gain_seen = 12'h000, mix_seen = 12'h000;
   int failures = 0, comparisons = 0;
   initial forever #10 clk = ~clk;
   fplc_top #(.DEB_CYC(4), .LONG_CYC(200)) fplc_top_i (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat_w), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .enc_a(enc_a), .enc_b(enc_b), .enc_push(enc_push), .disp_target_ff(tgt),
      .disp_value_ff(value), .disp_show_level_ff(show_lvl), .disp_show_link_ff(show_link),
      .disp_dot_ff(dot), .led_mode_green_ff(green), .led_signal_ff(led_sig), .led_over_ff(led_over),
      .peak_pair0(peak0), .peak_pair1(peak1), .gain_addr_ff(gain_addr), .gain_code_ff(gain_code),
      .gain_we_ff(gain_we), .mix_addr_ff(mix_addr), .mix_code_ff(mix_code), .mix_we_ff(mix_we),
      .nv_addr_ff(nv_addr), .nv_wdata_ff(nv_wdata), .nv_we_ff(nv_we), .nv_re_ff(nv_re),
      .nv_rdata(nv_rdata), .nv_done(nv_done));
   fplc_nv_model fplc_nv_model_i (.clk(clk), .addr(nv_addr), .wdata(nv_wdata), .we(nv_we), .re(nv_re),
      .rdata(nv_rdata), .done(nv_done));
   // Last analog gain and mixer updates, for path checks
   always @(posedge clk) begin
      if (gain_we === 1'b1) gain_seen <= {gain_addr, gain_code};
      if (mix_we === 1'b1) mix_seen <= {mix_addr, mix_code};
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // One classic cycle; the answer is awaited, never assumed
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      r = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20) chk(32'h0, 32'h1);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   // Level writes are dropped while the store is busy, so wait it out
   task automatic idle();
      int n;
      n = 0;
      do begin
         bus(1'b0, `FPLC_REG_STATUS, 32'h0, q);
         n++;
      end while (q[2] !== 1'b0 && n < 400);
      if (q[2] !== 1'b0) chk(32'h0, 32'h1);
   endtask
   task automatic setlvl(input logic [31:0] t, input logic [31:0] v);
      idle();
      wr(`FPLC_REG_LVL_WIN, t);
      wr(`FPLC_REG_LVL_DATA, v);
      idle();
   endtask
   // Read data lags the window write, hence the second read
   task automatic getlvl(input logic [31:0] t);
      wr(`FPLC_REG_LVL_WIN, t);
      bus(1'b0, `FPLC_REG_LVL_DATA, 32'h0, q);
      bus(1'b0, `FPLC_REG_LVL_DATA, 32'h0, q);
   endtask
   task automatic turn(input logic up, input int k);
      repeat (k) begin
         @(posedge clk);
         enc_b <= !up;
         repeat (16) @(posedge clk);
         enc_a <= 1'b1;
         repeat (16) @(posedge clk);
         enc_a <= 1'b0;
         repeat (16) @(posedge clk);
      end
      idle();
   endtask
   task automatic push(input int len);
      @(posedge clk);
      enc_push <= 1'b1;
      repeat (len) @(posedge clk);
      enc_push <= 1'b0;
      repeat (16) @(posedge clk);
      idle();
   endtask
   task automatic final_report();
      if (failures == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      final_report();
   end
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      idle();
      bus(1'b0, `FPLC_REG_SETUP, 32'h0, q);
      chk(q, 32'h000000A5);
      getlvl(0);
      chk(q, 32'd20);
      bus(1'b0, 8'h1C, 32'h0, q);
      chk(q, 32'h0);
      wr(`FPLC_REG_SETUP, 32'h1234);
      idle();
      chk(32'(fplc_nv_model_i.mem[20]), 32'h1234);
      wr(`FPLC_REG_CTRL, 32'h1);
      idle();
      bus(1'b0, `FPLC_REG_SETUP, 32'h0, q);
      chk(q, 32'h1234);
      setlvl(2, 5);
      getlvl(2);
      chk(q, 32'd5);
      turn(1, 2);
      bus(1'b0, `FPLC_REG_SEL, 32'h0, q);
      chk(q, 32'd2);
      push(20);
      bus(1'b0, `FPLC_REG_STATUS, 32'h0, q);
      chk(32'(q[0]), 32'h1);
      chk(32'(green), 32'h1);
      turn(1, 1);
      chk(32'(dot), 32'h0);
      chk(32'(gain_seen), {20'h0, 5'd2, 7'd6});
      getlvl(2);
      chk(q, 32'd6);
      turn(0, 1);
      chk(32'(dot), 32'h1);
      setlvl(2, 36);
      turn(1, 1);
      getlvl(2);
      chk(q, 32'd36);
      push(20);
      turn(0, 2);
      push(20);
      setlvl(0, 10);
      turn(0, 1);
      getlvl(0);
      chk(q, 32'd0);
      turn(1, 1);
      getlvl(0);
      chk(q, 32'd10);
      push(20);
      turn(1, 4);
      push(20);
      setlvl(4, 1);
      turn(0, 1);
      chk(32'(mix_seen), {20'h0, 5'd4, 7'd0});
      setlvl(4, 65);
      turn(1, 1);
      getlvl(4);
      chk(q, 32'd65);
      push(300);
      chk({30'h0, show_link, value[0]}, 32'h3);
      bus(1'b0, `FPLC_REG_STATUS, 32'h0, q);
      chk(32'(q[1]), 32'h1);
      turn(0, 1);
      getlvl(5);
      chk(q, 32'd64);
      push(20);
      turn(1, 1);
      bus(1'b0, `FPLC_REG_SEL, 32'h0, q);
      chk(q, 32'd6);
      peak0 <= 16'h65AC;
      peak1 <= 16'h0013;
      bus(1'b0, `FPLC_REG_METER, 32'h0, q);
      bus(1'b0, `FPLC_REG_METER, 32'h0, q);
      chk(q, 32'h7);
      peak0 <= 16'h65AB;
      peak1 <= 16'h0012;
      repeat (8) @(posedge clk);
      chk({28'h0, led_over, led_sig}, 32'h1);
      final_report();
   end
endmodule // fplc_top_tb
